// >>> ppvc_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppvc_link_model (
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire logic            turn_off_msg,
    input  wire logic            up,
    input  wire logic            slow,
    input  wire logic            hs,
    output var ppvc_pkg::ppvc_link_t link_in
);
    logic [5:0] cnt;
    assign link_in.link_active = up;
    assign link_in.dl_down = !up;
    assign link_in.hot_swap_evt = hs;
    // acknowledge after message, never while down
    assign link_in.turn_off_ack_in = up && cnt != 6'h00 && cnt < 6'h03;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) cnt <= 6'h00;
        else if (turn_off_msg) cnt <= slow ? 6'h28 : 6'h04;
        else if (cnt != 6'h00) cnt <= cnt - 6'h01;
    end
endmodule : ppvc_link_model
`default_nettype wire

// >>> ppvc_pkg.sv
// Summary of operation
// - Timer-disable bit set stops the completion timeout timer; clear lets it run.
// - Routing bit clear sends hot-swap events to GPE; set sends them as INTx/MSI.
// - Hot-swap routing is not gated by error throttling or injection settings.
// - Loopback bit set forces Enable Loopback in every transmitted TS1/TS2.
// - Software writing one sets turn-off request, which sends PME Turn Off message.
// - Hardware clears turn-off request on acknowledge or while link layer is down.
// - Link-active status bit mirrors the link layer's link-active indication.
// - Acknowledge with request pending sets turn-off ack and clears the request.
// - Turn-off ack clears by writing one, and while link layer is down.
// - Capability ID byte reads 01h and ignores writes.
// - Next-capability pointer byte reads 58h and ignores writes.
// - Hot-swap status byte is read-only zero.
// - Secondary reset bit forces link hot reset without clearing these registers.
package ppvc_pkg;
    localparam logic [7:0] PPVC_OFS_CMD1     = 8'h45;
    localparam logic [7:0] PPVC_OFS_STS0     = 8'h46;
    localparam logic [7:0] PPVC_OFS_STS1     = 8'h47;
    localparam logic [7:0] PPVC_OFS_CAPID    = 8'h50;
    localparam logic [7:0] PPVC_OFS_NPTR     = 8'h51;
    localparam logic [7:0] PPVC_OFS_IRQ_STS  = 8'h60;
    localparam logic [7:0] PPVC_OFS_IRQ_MASK = 8'h61;
    localparam logic [7:0] PPVC_OFS_BRCTL    = 8'h62;
    localparam logic [7:0] PPVC_CAPID_VAL    = 8'h01;
    localparam logic [7:0] PPVC_NPTR_VAL     = 8'h58;
    localparam logic [7:0] PPVC_ZERO         = 8'h00;
    localparam int PPVC_BIT_TOR    = 0;
    localparam int PPVC_BIT_LOOP   = 1;
    localparam int PPVC_BIT_GPEDIS = 2;
    localparam int PPVC_BIT_TODIS  = 3;
    localparam int PPVC_BIT_TOA    = 0;
    localparam int PPVC_BIT_LINK   = 1;
    localparam int PPVC_BIT_SRST   = 6;
    // Interrupt status/mask bits
    localparam int PPVC_IRQ_ACK    = 0;
    localparam int PPVC_IRQ_LUP    = 1;
    localparam int PPVC_IRQ_LDN    = 2;
    localparam logic [3:0] PPVC_CMD1_MASK = 4'hF;
    localparam logic [2:0] PPVC_IRQ_MASKW = 3'h7;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ppvc_bus_t;

    typedef struct packed {
        logic       link_active;
        logic       dl_down;
        logic       turn_off_ack_in;
        logic       hot_swap_evt;
    } ppvc_link_t;

    typedef struct packed {
        logic [3:0] cmd;
        logic       toa;
        logic       link_s1;
        logic       link_s2;
        logic       link_d;
        logic       dl_s1;
        logic       dl_s2;
        logic       ack_s1;
        logic       ack_s2;
        logic       ack_d;
        logic       hs_s1;
        logic       hs_s2;
        logic       tor_d;
        logic       turn_off_msg;
        logic [2:0] irq_sts;
        logic [2:0] irq_mask;
        logic       srst;
        logic [7:0] rdata;
    } ppvc_state_t;
endpackage : ppvc_pkg

// >>> ppvc_props.sv
`timescale 1ns/10ps
`default_nettype none
module ppvc_props (
    input wire logic                clk_sys,
    input wire logic                rstn,
    input wire ppvc_pkg::ppvc_bus_t bus,
    input wire logic [7:0]          rdata,
    input wire logic                cpl_timer_run,
    input wire logic                hs_gpe_evt,
    input wire logic                ts_loopback_force,
    input wire logic                turn_off_msg,
    input wire logic                secondary_link_hot_reset
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire [7:0] a = bus.addr;
    capability_code_a: assert property (bus.rd && a == 8'h50 |=> rdata == 8'h01)
        else $error("capability id wrong");
    next_ptr_a: assert property (bus.rd && a == 8'h51 |=> rdata == 8'h58)
        else $error("next pointer wrong");
    hs_zero_a: assert property (bus.rd && a == 8'h46 |=> rdata == 8'h00)
        else $error("hot swap status not zero");
    cmd_rsvd_a: assert property (bus.rd && a == 8'h45 |=> rdata[7:4] == 4'h0)
        else $error("reserved command bits set");
    timer_ctl_a: assert property (bus.wr && a == 8'h45 |=>
        cpl_timer_run != $past(bus.wdata[3])) else $error("timer run wrong");
    loop_ctl_a: assert property (bus.wr && a == 8'h45 |=>
        ts_loopback_force == $past(bus.wdata[1])) else $error("loopback wrong");
    gpe_off_a: assert property (bus.wr && a == 8'h45 && bus.wdata[2] |=> ##1 !hs_gpe_evt)
        else $error("gpe event not suppressed");
    msg_pulse_a: assert property (turn_off_msg |=> !turn_off_msg)
        else $error("turn off message too long");
    hot_rst_a: assert property (bus.wr && a == 8'h62 |=>
        secondary_link_hot_reset == $past(bus.wdata[6])) else $error("hot reset wrong");
    cover property (turn_off_msg);
    cover property (!hs_gpe_evt ##1 hs_gpe_evt);
    cover property (secondary_link_hot_reset);
endmodule : ppvc_props
bind ppvc_regs ppvc_props ppvc_props_i (.clk_sys(clk_sys), .rstn(rstn), .bus(bus),
    .rdata(rdata), .cpl_timer_run(cpl_timer_run), .hs_gpe_evt(hs_gpe_evt),
    .ts_loopback_force(ts_loopback_force), .turn_off_msg(turn_off_msg),
    .secondary_link_hot_reset(secondary_link_hot_reset));
`default_nettype wire

// >>> ppvc_regs.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ppvc_regs (
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    input  wire ppvc_pkg::ppvc_bus_t  bus,
    output logic [7:0]              rdata,
    input  wire ppvc_pkg::ppvc_link_t link_in,
    input  wire logic               err_throttle,
    output logic                    cpl_timer_run,
    output logic                    hs_gpe_evt,
    output logic                    hs_msi_evt,
    output logic                    ts_loopback_force,
    output logic                    turn_off_msg,
    output logic                    secondary_link_hot_reset,
    output logic                    irq
);
    ppvc_pkg::ppvc_state_t st;
    ppvc_pkg::ppvc_state_t next_st;
    logic                  wr_cmd1;
    logic                  wr_sts1;
    logic                  ack_rise;
    logic                  req_pending;
    logic                  ack_take;
    logic                  dl_down_now;
    logic                  link_up_evt;
    logic                  link_down_evt;

    // Write strobe aimed at one byte offset
    function automatic logic ppvc_wr_hit(
        input ppvc_pkg::ppvc_bus_t b,
        input logic [7:0]          ofs
    );
        return b.wr && (b.addr == ofs);
    endfunction : ppvc_wr_hit

    // Rising edge between two consecutive synchronised samples
    function automatic logic ppvc_rise(
        input logic prev,
        input logic cur
    );
        return cur && !prev;
    endfunction : ppvc_rise

    // Falling edge between two consecutive synchronised samples
    function automatic logic ppvc_fall(
        input logic prev,
        input logic cur
    );
        return prev && !cur;
    endfunction : ppvc_fall

    // Status byte with link and acknowledge bits at their positions
    function automatic logic [7:0] ppvc_sts1_word(
        input logic link,
        input logic ack
    );
        logic [7:0] w;
        w = ppvc_pkg::PPVC_ZERO;
        w[ppvc_pkg::PPVC_BIT_LINK] = link;
        w[ppvc_pkg::PPVC_BIT_TOA]  = ack;
        return w;
    endfunction : ppvc_sts1_word

    // Three-bit interrupt field widened to a byte
    function automatic logic [7:0] ppvc_ext3(
        input logic [2:0] v
    );
        return {5'h00, v};
    endfunction : ppvc_ext3

    always_comb begin
        next_st = st;
        wr_cmd1 = ppvc_wr_hit(bus, ppvc_pkg::PPVC_OFS_CMD1);
        wr_sts1 = ppvc_wr_hit(bus, ppvc_pkg::PPVC_OFS_STS1);
        next_st.link_s1 = link_in.link_active;
        next_st.link_s2 = st.link_s1;
        // Edge history taken from the second stage only
        next_st.link_d  = st.link_s2;
        next_st.dl_s1   = link_in.dl_down;
        next_st.dl_s2   = st.dl_s1;
        next_st.ack_s1  = link_in.turn_off_ack_in;
        next_st.ack_s2  = st.ack_s1;
        next_st.ack_d   = st.ack_s2;
        next_st.hs_s1   = link_in.hot_swap_evt;
        next_st.hs_s2   = st.hs_s1;
        ack_rise      = ppvc_rise(st.ack_d, st.ack_s2);
        req_pending   = st.cmd[ppvc_pkg::PPVC_BIT_TOR];
        ack_take      = ack_rise && req_pending;
        dl_down_now   = st.dl_s2;
        link_up_evt   = ppvc_rise(st.link_d, st.link_s2);
        link_down_evt = ppvc_fall(st.link_d, st.link_s2);
        if (wr_cmd1) begin
            next_st.cmd[3:1] = bus.wdata[3:1] & ppvc_pkg::PPVC_CMD1_MASK[3:1];
            if (bus.wdata[ppvc_pkg::PPVC_BIT_TOR]) begin
                next_st.cmd[ppvc_pkg::PPVC_BIT_TOR] = 1'b1;
            end
        end
        if (wr_sts1 && bus.wdata[ppvc_pkg::PPVC_BIT_TOA]) begin
            next_st.toa = 1'b0;
        end
        if (ack_take) begin
            next_st.toa = 1'b1;
            next_st.cmd[ppvc_pkg::PPVC_BIT_TOR] = 1'b0;
        end
        if (dl_down_now) begin
            next_st.cmd[ppvc_pkg::PPVC_BIT_TOR] = 1'b0;
            next_st.toa = 1'b0;
        end
        // Message pulse on rising request
        next_st.tor_d        = st.cmd[ppvc_pkg::PPVC_BIT_TOR];
        next_st.turn_off_msg = st.cmd[ppvc_pkg::PPVC_BIT_TOR] && !st.tor_d;
        // Interrupt status, set wins over write-one clear
        if (ppvc_wr_hit(bus, ppvc_pkg::PPVC_OFS_IRQ_STS)) begin
            next_st.irq_sts = st.irq_sts & ~bus.wdata[2:0];
        end
        if (ack_take) begin
            next_st.irq_sts[ppvc_pkg::PPVC_IRQ_ACK] = 1'b1;
        end
        if (link_down_evt) begin
            next_st.irq_sts[ppvc_pkg::PPVC_IRQ_LDN] = 1'b1;
        end
        if (link_up_evt) begin
            next_st.irq_sts[ppvc_pkg::PPVC_IRQ_LUP] = 1'b1;
        end
        if (ppvc_wr_hit(bus, ppvc_pkg::PPVC_OFS_IRQ_MASK)) begin
            next_st.irq_mask = bus.wdata[2:0] & ppvc_pkg::PPVC_IRQ_MASKW;
        end
        if (ppvc_wr_hit(bus, ppvc_pkg::PPVC_OFS_BRCTL)) begin
            next_st.srst = bus.wdata[ppvc_pkg::PPVC_BIT_SRST];
        end
        next_st.rdata = ppvc_pkg::PPVC_ZERO;
        if (bus.rd) begin
            case (bus.addr)
                ppvc_pkg::PPVC_OFS_CMD1: begin
                    next_st.rdata = {4'h0, st.cmd};
                end
                ppvc_pkg::PPVC_OFS_STS0: begin
                    next_st.rdata = ppvc_pkg::PPVC_ZERO;
                end
                ppvc_pkg::PPVC_OFS_STS1: begin
                    next_st.rdata = ppvc_sts1_word(st.link_s2, st.toa);
                end
                ppvc_pkg::PPVC_OFS_CAPID: begin
                    next_st.rdata = ppvc_pkg::PPVC_CAPID_VAL;
                end
                ppvc_pkg::PPVC_OFS_NPTR: begin
                    next_st.rdata = ppvc_pkg::PPVC_NPTR_VAL;
                end
                ppvc_pkg::PPVC_OFS_IRQ_STS: begin
                    next_st.rdata = ppvc_ext3(st.irq_sts);
                end
                ppvc_pkg::PPVC_OFS_IRQ_MASK: begin
                    next_st.rdata = ppvc_ext3(st.irq_mask);
                end
                ppvc_pkg::PPVC_OFS_BRCTL: begin
                    next_st.rdata = {1'b0, st.srst, 6'h00};
                end
                default: begin
                    next_st.rdata = ppvc_pkg::PPVC_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign cpl_timer_run = !st.cmd[ppvc_pkg::PPVC_BIT_TODIS];
    assign hs_gpe_evt = st.hs_s2 && !st.cmd[ppvc_pkg::PPVC_BIT_GPEDIS];
    assign hs_msi_evt = st.hs_s2 && st.cmd[ppvc_pkg::PPVC_BIT_GPEDIS];
    assign ts_loopback_force = st.cmd[ppvc_pkg::PPVC_BIT_LOOP];
    assign turn_off_msg = st.turn_off_msg;
    assign secondary_link_hot_reset = st.srst;
    assign irq = |(st.irq_sts & st.irq_mask);

    logic unused_ok;
    assign unused_ok = err_throttle;
endmodule : ppvc_regs
`default_nettype wire

// >>> test_pcie_port_vendor_ctrl_status.sv
`timescale 1ns/10ps
`default_nettype none
module test_pcie_port_vendor_ctrl_status;
    logic                 clk_sys = 1'b0;
    logic                 rstn = 1'b0;
    ppvc_pkg::ppvc_bus_t  bus = '0;
    ppvc_pkg::ppvc_link_t link_in;
    logic [7:0]           rdata;
    logic                 err_throttle = 1'b0, up = 1'b0, slow = 1'b0, hs = 1'b0;
    logic                 tmr, gpe, msi, lpb, msg, hrst, irq;
    logic                 rd_d = 1'b0;
    logic [7:0]           q[$];
    logic [7:0]           cmd = 8'h00;
    logic [7:0]           adr[5] = '{8'h46, 8'h50, 8'h51, 8'h70, 8'h47};
    logic [7:0]           exv[5] = '{8'h00, 8'h01, 8'h58, 8'h00, 8'h00};
    int                   bad_count = 0, compares = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    ppvc_regs ppvc_regs_i (.clk_sys(clk_sys), .rstn(rstn), .bus(bus), .rdata(rdata),
        .link_in(link_in), .err_throttle(err_throttle), .cpl_timer_run(tmr),
        .hs_gpe_evt(gpe), .hs_msi_evt(msi), .ts_loopback_force(lpb),
        .turn_off_msg(msg), .secondary_link_hot_reset(hrst), .irq(irq));
    ppvc_link_model ppvc_link_model_i (.clk_sys(clk_sys), .rstn(rstn),
        .turn_off_msg(msg), .up(up), .slow(slow), .hs(hs), .link_in(link_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{a, d, w, !w};
        if (!w) q.push_back(d);
        @(posedge clk_sys);
        bus <= '0;
    endtask : acc
    task automatic settle();
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle
    task automatic turn_off(input logic s);
        slow <= s;
        acc(1'b1, 8'h45, cmd | 8'h01);
        settle();
        chk({7'h00, msg}, 8'h01);
        for (int i = 0; i < 60 && !s && irq !== 1'b1; i++) @(posedge clk_sys);
    endtask : turn_off
    always @(posedge clk_sys) begin
        rd_d <= bus.rd;
        if (rd_d) chk(rdata, q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(1848));
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        settle();
        chk({7'h00, tmr}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, adr[i], 8'hFF);
            acc(1'b0, adr[i], exv[i]);
        end
        $display("test fixed bytes done");
        hs <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            cmd = 8'($urandom);
            err_throttle <= cmd[7];
            cmd[2] = i[0];
            acc(1'b1, 8'h45, cmd & 8'hFE);
            cmd &= 8'h0E;
            acc(1'b0, 8'h45, cmd);
            repeat (3) settle();
            chk({7'h00, tmr}, {7'h00, !cmd[3]});
            chk({7'h00, lpb}, {7'h00, cmd[1]});
            chk({6'h00, gpe, msi}, cmd[2] ? 8'h01 : 8'h02);
        end
        $display("test controls done");
        up <= 1'b1;
        acc(1'b1, 8'h61, 8'h01);
        repeat (3) settle();
        acc(1'b0, 8'h47, 8'h02);
        turn_off(1'b0);
        acc(1'b0, 8'h47, 8'h03);
        acc(1'b0, 8'h45, cmd);
        acc(1'b1, 8'h47, 8'h00);
        acc(1'b0, 8'h47, 8'h03);
        acc(1'b1, 8'h47, 8'h01);
        acc(1'b0, 8'h47, 8'h02);
        acc(1'b1, 8'h61, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        acc(1'b1, 8'h61, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h01);
        acc(1'b1, 8'h60, 8'h07);
        settle();
        chk({7'h00, irq}, 8'h00);
        acc(1'b0, 8'h60, 8'h00);
        acc(1'b0, 8'h61, 8'h01);
        $display("test turn off done");
        turn_off(1'b0);
        up <= 1'b0;
        repeat (3) settle();
        acc(1'b0, 8'h47, 8'h00);
        up <= 1'b1;
        repeat (3) settle();
        turn_off(1'b1);
        up <= 1'b0;
        repeat (3) settle();
        acc(1'b0, 8'h45, cmd);
        acc(1'b0, 8'h47, 8'h00);
        acc(1'b1, 8'h62, 8'h40);
        settle();
        chk({7'h00, hrst}, 8'h01);
        acc(1'b0, 8'h62, 8'h40);
        acc(1'b0, 8'h45, cmd);
        acc(1'b1, 8'h62, 8'h00);
        repeat (3) settle();
        acc(1'b0, 8'h60, 8'h07);
        $display("test link down done");
        stop_test();
    end
endmodule : test_pcie_port_vendor_ctrl_status
`default_nettype wire
